// file: dv/lbt_led_blink_timing_sva.sv
`timescale 1ns/1ps
module lbt_led_blink_timing_sva #(
   parameter int CLK_HZ = 20000000
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic hardware_reset_pin_n_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [5:0] sink_above_thresh_i,
   input wire logic [2:0] col_drive_o,
   input wire logic next_data_req_o,
   input wire logic [3:0] gpo_o,
   input wire logic pump_en_o,
   input wire logic pump_clk_o,
   input wire logic pump_ratio_15x_o
);
   // --------------------
   // Helper counters
   // --------------------
   // Slowest column tick bounds the request level, plus margin
   localparam int REQ_MAX = CLK_HZ * 4 / (694 * 3) + 4;
   logic [31:0] req_cnt;
   logic [3:0] pin_cnt;
   logic [3:0] hi_cnt;
   logic [3:0] lo_cnt;
   logic [3:0] en_cnt;
   always_ff @(posedge clk_i) begin
      if (!rst_b_i || !next_data_req_o) begin
         req_cnt <= '0;
      end else begin
         req_cnt <= req_cnt + 32'h1;
      end
   end
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         pin_cnt <= 4'h0;
         hi_cnt <= 4'h0;
         lo_cnt <= 4'h0;
         en_cnt <= 4'h0;
      end else begin
         pin_cnt <= !hardware_reset_pin_n_i ? 4'h0 : pin_cnt + {3'h0, pin_cnt != 4'hF};
         hi_cnt <= !(&sink_above_thresh_i) ? 4'h0 : hi_cnt + {3'h0, hi_cnt != 4'hF};
         lo_cnt <= (&sink_above_thresh_i) ? 4'h0 : lo_cnt + {3'h0, lo_cnt != 4'hF};
         en_cnt <= !pump_en_o ? 4'h0 : en_cnt + {3'h0, en_cnt != 4'hF};
      end
   end
   // --------------------
   // Properties
   // --------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   AST_COL_ONEHOT: assert property ($onehot(col_drive_o))
      else $error("column drive not one-hot");
   AST_STANDBY_COL: assert property (!pump_en_o [*2] |-> col_drive_o == 3'h1)
      else $error("column not parked in standby");
   AST_STANDBY_PUMP: assert property (!pump_en_o [*2] |-> !pump_clk_o)
      else $error("pump clock runs in standby");
   AST_REQ_LEN: assert property (req_cnt <= 32'(REQ_MAX))
      else $error("data request longer than a column tick");
   AST_RATIO_1X: assert property (hi_cnt >= 4'h4 && en_cnt >= 4'h4 |-> !pump_ratio_15x_o)
      else $error("pump boosts with all pins above threshold");
   AST_RATIO_15X: assert property (lo_cnt >= 4'h4 && en_cnt >= 4'h4 |-> pump_ratio_15x_o)
      else $error("pump stays 1x with a low pin");
   AST_PIN_RESET: assert property (!hardware_reset_pin_n_i [*5] |-> gpo_o == 4'h0 && !pump_en_o)
      else $error("reset pin does not clear state");
   AST_GPO_WRITE: assert property (reg_wr_i && reg_addr_i == 8'h01 && !reg_wdata_i[7]
      && !reg_wdata_i[4] && pin_cnt >= 4'h3 |-> ##2 gpo_o == $past(reg_wdata_i[3:0], 2))
      else $error("general outputs do not follow write");
   AST_SOFT_RESET: assert property (reg_wr_i && reg_addr_i == 8'h01 && reg_wdata_i[7]
      && pin_cnt >= 4'h3 |=> ##1 (gpo_o == 4'h0 && !pump_en_o) [*3])
      else $error("software reset does not clear state");
endmodule
bind lbt_led_blink_timing lbt_led_blink_timing_sva #(.CLK_HZ(CLK_HZ)) lbt_led_blink_timing_sva_i (
   .clk_i(clk_i),
   .rst_b_i(rst_b_i),
   .hardware_reset_pin_n_i(hardware_reset_pin_n_i),
   .reg_wr_i(reg_wr_i),
   .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i),
   .sink_above_thresh_i(sink_above_thresh_i),
   .col_drive_o(col_drive_o),
   .next_data_req_o(next_data_req_o),
   .gpo_o(gpo_o),
   .pump_en_o(pump_en_o),
   .pump_clk_o(pump_clk_o),
   .pump_ratio_15x_o(pump_ratio_15x_o)
);

// file: dv/lbt_led_blink_timing_tb.sv
`timescale 1ns/1ps
module lbt_led_blink_timing_tb;
   // --------------------
   // Bench setup
   // --------------------
   // Slow clock figure keeps cycle periods to a few thousand clocks
   localparam int CLK_HZ_TB = 20000;
   localparam int TMO = 60000;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic pin_low = 1'b0;
   logic reg_wr_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00;
   logic [7:0] reg_wdata_i = 8'h00;
   logic [5:0] sag = 6'h00;
   logic hardware_reset_pin_n_i;
   logic [5:0] sink_above_thresh_i;
   logic [7:0] reg_rdata_o;
   logic [71:0] chan_current_o;
   logic [2:0] col_drive_o;
   logic next_data_req_o;
   logic [3:0] gpo_o;
   logic pump_en_o;
   logic pump_clk_o;
   logic pump_ratio_15x_o;
   logic pump_soft_start_o;
   int error_cnt = 0;
   int checked = 0;
   int cyc = 0;
   always #25 clk_i = ~clk_i;
   lbt_led_blink_timing #(.CLK_HZ(CLK_HZ_TB)) lbt_led_blink_timing_i (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .hardware_reset_pin_n_i(hardware_reset_pin_n_i),
      .reg_wr_i(reg_wr_i),
      .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i),
      .sink_above_thresh_i(sink_above_thresh_i),
      .reg_rdata_o(reg_rdata_o),
      .chan_current_o(chan_current_o),
      .col_drive_o(col_drive_o),
      .next_data_req_o(next_data_req_o),
      .gpo_o(gpo_o),
      .pump_en_o(pump_en_o),
      .pump_clk_o(pump_clk_o),
      .pump_ratio_15x_o(pump_ratio_15x_o),
      .pump_soft_start_o(pump_soft_start_o)
   );
   lbt_led_side_model lbt_led_side_model_i (
      .pin_pull_low_i(pin_low),
      .sink_sag_i(sag),
      .hardware_reset_pin_n_o(hardware_reset_pin_n_i),
      .sink_above_thresh_o(sink_above_thresh_i)
   );
   // --------------------
   // Tasks
   // --------------------
   task automatic results();
      if (error_cnt == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == TMO) begin
         error_cnt++;
         results();
      end
   end
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic near(input string name, input int exp, input int got, input int tol);
      checked++;
      if (got < exp - tol || got > exp + tol) begin
         error_cnt++;
         $display("ERROR %s expected %0d seen %0d", name, exp, got);
      end
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      cycles(1);
      reg_wr_i = 1'b1;
      reg_addr_i = a;
      reg_wdata_i = d;
      cycles(1);
      reg_wr_i = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      cycles(1);
      reg_addr_i = a;
      cycles(1);
      chk("rdata", {8'h00, exp}, {8'h00, reg_rdata_o});
   endtask
   // Pair bytes put the even channel in the high nibble
   task automatic cur(input logic [7:0] p0, input logic [7:0] p8);
      chk("current", {p8[3:0], p8[7:4], p0[3:0], p0[7:4]},
         {chan_current_o[71:64], chan_current_o[7:0]});
   endtask
   task automatic col_tick(output int n);
      logic [2:0] c;
      for (int k = 0; k < 2; k++) begin
         n = 0;
         c = col_drive_o;
         while (col_drive_o === c && n < 200) begin
            cycles(1);
            n++;
         end
      end
   endtask
   task automatic next_req(output int at);
      int n;
      n = 0;
      while (next_data_req_o !== 1'b0 && n < 30000) begin
         cycles(1);
         n++;
      end
      while (next_data_req_o !== 1'b1 && n < 30000) begin
         cycles(1);
         n++;
      end
      at = cyc;
      cycles(3);
   endtask
   function automatic int tick_exp(input logic [1:0] osc, input logic [1:0] div);
      int base[4] = '{1146, 1016, 859, 694};
      int mul[4] = '{4, 8, 3, 6};
      return CLK_HZ_TB * 4 / (base[osc] * mul[div]);
   endfunction
   // --------------------
   // Main sequence
   // --------------------
   initial begin
      int t0;
      int t1;
      int tk;
      static logic [2:0] oscs[4] = '{3'h0, 3'h4, 3'h3, 3'h5};
      static logic [1:0] divs[4] = '{2'h0, 2'h0, 2'h2, 2'h3};
      cycles(8);
      rst_b_i = 1'b1;
      cycles(3);
      chk("standby", 16'h0001, {11'h000, pump_en_o, gpo_o[0], col_drive_o});
      rd(8'h01, 8'h00);
      rd(8'h06, 8'h00);
      wr(8'h04, 8'hFF);
      rd(8'h04, 8'h00);
      wr(8'h01, 8'h0F);
      cycles(2);
      chk("gpo", 16'h000F, {12'h000, gpo_o});
      for (int k = 0; k < 4; k++) begin
         wr(8'h01, 8'h00);
         wr(8'h06, {5'h00, oscs[k]});
         wr(8'h02, {6'h00, divs[k]});
         wr(8'h01, 8'h40);
         col_tick(tk);
         near("col tick", tick_exp(oscs[k][1:0], divs[k]), tk, 1);
      end
      chk("pump on", 16'h0001, {15'h0000, pump_en_o});
      chk("soft start", 16'h0000, {15'h0000, pump_soft_start_o});
      t0 = int'(pump_clk_o);
      cycles(1);
      chk("pump clk", 16'(t0 ^ 1), {15'h0000, pump_clk_o});
      wr(8'h01, 8'h00);
      wr(8'h06, 8'h00);
      wr(8'h02, 8'h00);
      wr(8'h07, 8'h5A);
      wr(8'h0F, 8'h96);
      wr(8'h17, 8'hC3);
      wr(8'h1F, 8'hE1);
      wr(8'h03, 8'h02);
      wr(8'h01, 8'h40);
      next_req(t0);
      cur(8'h5A, 8'h96);
      wr(8'h07, 8'h3C);
      cycles(4);
      cur(8'h5A, 8'h96);
      next_req(t1);
      cur(8'hC3, 8'hE1);
      near("cycle", 128 * tick_exp(2'h0, 2'h0), t1 - t0, 128);
      sag = 6'h04;
      cycles(6);
      chk("ratio", 16'h0001, {15'h0000, pump_ratio_15x_o});
      sag = 6'h00;
      cycles(6);
      chk("ratio", 16'h0000, {15'h0000, pump_ratio_15x_o});
      next_req(t0);
      cur(8'h3C, 8'h96);
      wr(8'h02, 8'h01);
      wr(8'h03, 8'h12);
      next_req(t0);
      next_req(t1);
      near("cycle", 256 * tick_exp(2'h0, 2'h1), t1 - t0, 256);
      wr(8'h01, 8'h00);
      wr(8'h03, 8'h0A);
      wr(8'h01, 8'h40);
      cycles(40);
      wr(8'h07, 8'h11);
      cycles(2400);
      cur(8'h3C, 8'h96);
      wr(8'h03, 8'h08);
      cycles(3);
      cur(8'h11, 8'h96);
      cycles(40);
      wr(8'h0F, 8'h22);
      cycles(1);
      cur(8'h11, 8'h22);
      wr(8'h01, 8'h00);
      wr(8'h03, 8'h03);
      cur(8'h00, 8'h00);
      wr(8'h01, 8'h40);
      cycles(1);
      cur(8'hFF, 8'hFF);
      wr(8'h01, 8'h00);
      wr(8'h03, 8'h01);
      wr(8'h01, 8'h50);
      next_req(t0);
      next_req(t0);
      chk("direction", 16'h0001, {15'h0000, gpo_o[2]});
      next_req(t0);
      chk("direction", 16'h0000, {15'h0000, gpo_o[2]});
      wr(8'h01, 8'h4A);
      wr(8'h01, 8'h80);
      cycles(2);
      chk("soft reset", 16'h0000, {11'h000, gpo_o, pump_en_o});
      wr(8'h03, 8'h22);
      rd(8'h03, 8'h00);
      wr(8'h01, 8'h00);
      wr(8'h03, 8'h22);
      rd(8'h03, 8'h22);
      wr(8'h01, 8'h4F);
      wr(8'h02, 8'h03);
      pin_low = 1'b1;
      cycles(3);
      wr(8'h02, 8'h01);
      cycles(2);
      chk("pin reset", 16'h0001, {8'h00, gpo_o, pump_en_o, col_drive_o});
      pin_low = 1'b0;
      cycles(3);
      rd(8'h02, 8'h00);
      results();
   end
endmodule

// file: dv/lbt_led_side_model.sv
`timescale 1ns/1ps
// --------------------
// Board side: reset pin pull-up, sink comparators
// --------------------
module lbt_led_side_model (
   input wire logic pin_pull_low_i,
   input wire logic [5:0] sink_sag_i,
   output logic hardware_reset_pin_n_o,
   output logic [5:0] sink_above_thresh_o
);
   // Pull-up keeps the pin inactive unless the host pulls it down
   assign hardware_reset_pin_n_o = !pin_pull_low_i;
   // A sagging pin reads below threshold, so the pump must boost
   assign sink_above_thresh_o = ~sink_sag_i;
endmodule

// file: rtl/lbt_defs.svh
`ifndef LBT_DEFS_SVH
`define LBT_DEFS_SVH

// ------------------------------------------------------------
// Clock and register map
// ------------------------------------------------------------
`define LBT_CLK_HZ 20000000
`define LBT_HZ_PER_KHZ 1000
`define LBT_ADDR_STATUS 8'h00
`define LBT_ADDR_START 8'h01
`define LBT_ADDR_LEDS 8'h02
`define LBT_ADDR_MODE 8'h03
`define LBT_ADDR_CP 8'h06
`define LBT_ADDR_A_BASE 8'h07
`define LBT_ADDR_B_BASE 8'h17
`define LBT_PAIRS 9
`define LBT_CHANS 18
`define LBT_RESET_VAL 8'h00

// ------------------------------------------------------------
// Field positions and write masks
// ------------------------------------------------------------
`define LBT_START_MASK 8'hDF
`define LBT_LEDS_MASK 8'h03
`define LBT_MODE_MASK 8'h7F
`define LBT_CP_MASK 8'h37
`define LBT_SOFT_RESET_BIT 7
`define LBT_STANDBY_REL_BIT 6
`define LBT_RAMP_DIR_OUT_BIT 4
`define LBT_GENERAL_OUT_2_BIT 2
`define LBT_HOLD_BIT 3
`define LBT_CYCLE_LSB 4
`define LBT_OSC_LSB 0
`define LBT_SS_LSB 4
`define LBT_MAX_CURRENT 4'hF

// ------------------------------------------------------------
// Timing figures
// ------------------------------------------------------------
`define LBT_COL_HZ_0 1146
`define LBT_COL_HZ_1 1016
`define LBT_COL_HZ_2 859
`define LBT_COL_HZ_3 694
`define LBT_DIV_X1 4
`define LBT_DIV_X2 8
`define LBT_DIV_X075 3
`define LBT_DIV_X15 6
`define LBT_DIV_DEN 4
`define LBT_CYCLE_BASE 128
`define LBT_PUMP_KHZ_0 660
`define LBT_PUMP_KHZ_1 585
`define LBT_PUMP_KHZ_2 495
`define LBT_PUMP_KHZ_3 400
`define LBT_PUMP_KHZ_4 1320
`define LBT_PUMP_KHZ_5 1170
`define LBT_PUMP_KHZ_6 990
`define LBT_PUMP_KHZ_7 800
`define LBT_SS_NS_0 1500
`define LBT_SS_NS_1 3000
`define LBT_SS_NS_2 6100
`define LBT_SS_NS_3 12200
`define LBT_NS_PER_S_KHZ 1000000

`endif

// file: rtl/lbt_led_blink_timing.sv
`timescale 1ns/1ps
`include "lbt_defs.svh"
module lbt_led_blink_timing #(
   parameter int CLK_HZ = `LBT_CLK_HZ
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic hardware_reset_pin_n_i,
   input wire logic reg_wr_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [5:0] sink_above_thresh_i,
   output logic [7:0] reg_rdata_o,
   output logic [71:0] chan_current_o,
   output logic [2:0] col_drive_o,
   output logic next_data_req_o,
   output logic [3:0] gpo_o,
   output logic pump_en_o,
   output logic pump_clk_o,
   output logic pump_ratio_15x_o,
   output logic pump_soft_start_o
);

   // ------------------------------------------------------------
   // Divider tables
   // ------------------------------------------------------------
   function automatic logic [23:0] col_limit_f(input logic [1:0] osc, input logic [1:0] div);
      int base;
      int f4;
      base = `LBT_COL_HZ_0;
      f4 = 1;
      case (osc)
         2'h0: base = `LBT_COL_HZ_0;
         2'h1: base = `LBT_COL_HZ_1;
         2'h2: base = `LBT_COL_HZ_2;
         default: base = `LBT_COL_HZ_3;
      endcase
      case (div)
         2'h0: f4 = base * `LBT_DIV_X1;
         2'h1: f4 = base * `LBT_DIV_X2;
         2'h2: f4 = base * `LBT_DIV_X075;
         default: f4 = base * `LBT_DIV_X15;
      endcase
      return 24'((CLK_HZ * `LBT_DIV_DEN) / f4);
   endfunction

   function automatic int pump_khz_f(input logic [2:0] osc);
      int khz;
      khz = `LBT_PUMP_KHZ_0;
      case (osc)
         3'h0: khz = `LBT_PUMP_KHZ_0;
         3'h1: khz = `LBT_PUMP_KHZ_1;
         3'h2: khz = `LBT_PUMP_KHZ_2;
         3'h3: khz = `LBT_PUMP_KHZ_3;
         3'h4: khz = `LBT_PUMP_KHZ_4;
         3'h5: khz = `LBT_PUMP_KHZ_5;
         3'h6: khz = `LBT_PUMP_KHZ_6;
         default: khz = `LBT_PUMP_KHZ_7;
      endcase
      return khz;
   endfunction

   // Soft-start length in pump periods at the reset oscillator, rounded up
   function automatic logic [3:0] ss_periods_f(input logic [1:0] ss);
      int ns;
      ns = `LBT_SS_NS_0;
      case (ss)
         2'h0: ns = `LBT_SS_NS_0;
         2'h1: ns = `LBT_SS_NS_1;
         2'h2: ns = `LBT_SS_NS_2;
         default: ns = `LBT_SS_NS_3;
      endcase
      return 4'((ns * `LBT_PUMP_KHZ_0 + `LBT_NS_PER_S_KHZ - 1) / `LBT_NS_PER_S_KHZ);
   endfunction

   // ------------------------------------------------------------
   // Reset pin and sink comparator synchronisers
   // ------------------------------------------------------------
   logic hw_n_s1;
   logic hw_n_s2;
   logic [5:0] sink_s1;
   logic [5:0] sink_s2;

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         hw_n_s1 <= 1'b0;
         hw_n_s2 <= 1'b0;
      end else begin
         hw_n_s1 <= hardware_reset_pin_n_i;
         hw_n_s2 <= hw_n_s1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         sink_s1 <= 6'h00;
         sink_s2 <= 6'h00;
      end else begin
         sink_s1 <= sink_above_thresh_i;
         sink_s2 <= sink_s1;
      end
   end

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   logic [7:0] start_r;
   logic [7:0] leds_r;
   logic [7:0] mode_r;
   logic [7:0] cp_r;
   logic [7:0] a_r [`LBT_PAIRS];
   logic [7:0] b_r [`LBT_PAIRS];
   logic clr_all;
   logic soft_rst;
   logic wr_ok;
   logic [7:0] next_start;

   assign clr_all = !rst_b_i || !hw_n_s2;
   assign soft_rst = start_r[`LBT_SOFT_RESET_BIT];
   assign wr_ok = reg_wr_i && hw_n_s2;
   assign next_start = reg_wdata_i & `LBT_START_MASK;

   always_ff @(posedge clk_i) begin
      if (clr_all) begin
         start_r <= `LBT_RESET_VAL;
      end else if (wr_ok && reg_addr_i == `LBT_ADDR_START) begin
         if (next_start[`LBT_SOFT_RESET_BIT]) begin
            start_r <= `LBT_RESET_VAL | (8'h01 << `LBT_SOFT_RESET_BIT);
         end else begin
            start_r <= next_start;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (clr_all || soft_rst) begin
         leds_r <= `LBT_RESET_VAL;
         mode_r <= `LBT_RESET_VAL;
         cp_r <= `LBT_RESET_VAL;
      end else if (wr_ok) begin
         case (reg_addr_i)
            `LBT_ADDR_LEDS: leds_r <= reg_wdata_i & `LBT_LEDS_MASK;
            `LBT_ADDR_MODE: mode_r <= reg_wdata_i & `LBT_MODE_MASK;
            `LBT_ADDR_CP: cp_r <= reg_wdata_i & `LBT_CP_MASK;
            default: ;
         endcase
      end
   end

   // Test addresses and unmapped writes fall through untouched
   genvar p;
   generate
      for (p = 0; p < `LBT_PAIRS; p++) begin : g_pair
         always_ff @(posedge clk_i) begin
            if (clr_all || soft_rst) begin
               a_r[p] <= `LBT_RESET_VAL;
               b_r[p] <= `LBT_RESET_VAL;
            end else if (wr_ok) begin
               if (reg_addr_i == `LBT_ADDR_A_BASE + 8'(p)) begin
                  a_r[p] <= reg_wdata_i;
               end
               if (reg_addr_i == `LBT_ADDR_B_BASE + 8'(p)) begin
                  b_r[p] <= reg_wdata_i;
               end
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Mode decode
   // ------------------------------------------------------------
   lbt_pkg::lbt_mode_t mode;
   logic active;
   logic hold_on;
   logic seq_run;
   logic seq_run_d;
   logic seq_start;
   logic [2:0] cyc_sel;

   always_comb begin
      case (mode_r[2:0])
         3'h1: mode = lbt_pkg::LBT_RAMP;
         3'h2: mode = lbt_pkg::LBT_BLINK;
         3'h3: mode = lbt_pkg::LBT_ALL_HIGH;
         default: mode = lbt_pkg::LBT_NORMAL;
      endcase
   end

   assign active = start_r[`LBT_STANDBY_REL_BIT];
   assign hold_on = mode_r[`LBT_HOLD_BIT] && mode == lbt_pkg::LBT_BLINK;
   // Ramp interpolation lives elsewhere; here ramp steps like blink
   assign seq_run = active && (mode == lbt_pkg::LBT_BLINK || mode == lbt_pkg::LBT_RAMP);
   assign seq_start = seq_run && !seq_run_d;
   assign cyc_sel = mode_r[`LBT_CYCLE_LSB +: 3];

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         seq_run_d <= 1'b0;
      end else begin
         seq_run_d <= seq_run;
      end
   end

   // ------------------------------------------------------------
   // Column timebase and scan
   // ------------------------------------------------------------
   logic [23:0] col_cnt;
   logic [23:0] col_limit;
   logic col_tick;
   logic [1:0] scan;

   // Top oscillator bit only moves the pump, not the columns
   assign col_limit = col_limit_f(cp_r[`LBT_OSC_LSB +: 2], leds_r[1:0]);
   assign col_tick = col_cnt >= col_limit - 24'h000001;

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         col_cnt <= 24'h000000;
      end else if (col_tick) begin
         col_cnt <= 24'h000000;
      end else begin
         col_cnt <= col_cnt + 24'h000001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i || !active) begin
         scan <= 2'h0;
      end else if (col_tick) begin
         scan <= (scan == 2'h2) ? 2'h0 : scan + 2'h1;
      end
   end

   // Standby keeps only the red column lit
   always_ff @(posedge clk_i) begin
      if (!rst_b_i || !active) begin
         col_drive_o <= 3'h1;
      end else begin
         col_drive_o <= 3'h1 << scan;
      end
   end

   // ------------------------------------------------------------
   // Illumination cycle sequencer
   // ------------------------------------------------------------
   logic [14:0] cyc_cnt;
   logic [14:0] cyc_len;
   logic cyc_end;
   logic point_b;
   logic ramp_dir;
   logic [7:0] held_r [`LBT_PAIRS];

   assign cyc_len = 15'(`LBT_CYCLE_BASE) << cyc_sel;
   // Compare at or above, so shortening the cycle mid-run cannot wrap the counter
   assign cyc_end = seq_run && col_tick && cyc_cnt >= cyc_len - 15'h0001;

   always_ff @(posedge clk_i) begin
      if (!rst_b_i || !seq_run) begin
         cyc_cnt <= 15'h0000;
      end else if (col_tick) begin
         cyc_cnt <= cyc_end ? 15'h0000 : cyc_cnt + 15'h0001;
      end
   end

   // Every start begins at the first point
   always_ff @(posedge clk_i) begin
      if (!rst_b_i || !seq_run) begin
         point_b <= 1'b0;
      end else if (cyc_end && !hold_on) begin
         point_b <= !point_b;
      end
   end

   always_ff @(posedge clk_i) begin
      if (clr_all || soft_rst) begin
         ramp_dir <= 1'b0;
      end else if (cyc_end && !hold_on) begin
         ramp_dir <= !point_b;
      end
   end

   // Request rises at each switch so the host can stage the next values
   always_ff @(posedge clk_i) begin
      if (!rst_b_i || !seq_run) begin
         next_data_req_o <= 1'b0;
      end else if (seq_start || (cyc_end && !hold_on)) begin
         next_data_req_o <= 1'b1;
      end else if (col_tick) begin
         next_data_req_o <= 1'b0;
      end
   end

   // Snapshot per switch, so writes mid-cycle wait for the next one
   generate
      for (p = 0; p < `LBT_PAIRS; p++) begin : g_hold
         always_ff @(posedge clk_i) begin
            if (clr_all || soft_rst) begin
               held_r[p] <= `LBT_RESET_VAL;
            end else if (seq_start) begin
               held_r[p] <= a_r[p];
            end else if (cyc_end && !hold_on) begin
               held_r[p] <= point_b ? a_r[p] : b_r[p];
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Channel currents
   // ------------------------------------------------------------
   genvar c;
   generate
      for (c = 0; c < `LBT_CHANS; c++) begin : g_chan
         localparam int PAIR = c / 2;
         localparam int LSB = (c % 2 == 0) ? 4 : 0;
         always_ff @(posedge clk_i) begin
            if (!rst_b_i || !active) begin
               chan_current_o[c*4 +: 4] <= 4'h0;
            end else begin
               case (mode)
                  lbt_pkg::LBT_ALL_HIGH: chan_current_o[c*4 +: 4] <= `LBT_MAX_CURRENT;
                  lbt_pkg::LBT_NORMAL: chan_current_o[c*4 +: 4] <= a_r[PAIR][LSB +: 4];
                  default: begin
                     if (seq_start) begin
                        chan_current_o[c*4 +: 4] <= a_r[PAIR][LSB +: 4];
                     end else begin
                        chan_current_o[c*4 +: 4] <= held_r[PAIR][LSB +: 4];
                     end
                  end
               endcase
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // General outputs
   // ------------------------------------------------------------
   // Not gated by standby
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         gpo_o <= 4'h0;
      end else begin
         gpo_o <= start_r[3:0];
         if (start_r[`LBT_RAMP_DIR_OUT_BIT]) begin
            gpo_o[`LBT_GENERAL_OUT_2_BIT] <= ramp_dir;
         end
      end
   end

   // ------------------------------------------------------------
   // Charge pump control
   // ------------------------------------------------------------
   logic [11:0] pump_cnt;
   logic [11:0] pump_half;
   logic pump_edge;
   logic active_d;
   logic [3:0] ss_cnt;

   assign pump_half = 12'(CLK_HZ / (pump_khz_f(cp_r[`LBT_OSC_LSB +: 3]) * `LBT_HZ_PER_KHZ * 2));
   // A zero half period at slow clock figures toggles on every edge
   assign pump_edge = pump_cnt + 12'h001 >= pump_half;

   always_ff @(posedge clk_i) begin
      if (!rst_b_i || !active) begin
         pump_cnt <= 12'h000;
         pump_clk_o <= 1'b0;
      end else if (pump_edge) begin
         pump_cnt <= 12'h000;
         pump_clk_o <= !pump_clk_o;
      end else begin
         pump_cnt <= pump_cnt + 12'h001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         pump_en_o <= 1'b0;
         active_d <= 1'b0;
         pump_ratio_15x_o <= 1'b0;
      end else begin
         pump_en_o <= active;
         active_d <= active;
         pump_ratio_15x_o <= active && !(&sink_s2);
      end
   end

   // Counted in pump periods, so a slower oscillator stretches it
   always_ff @(posedge clk_i) begin
      if (!rst_b_i || !active) begin
         ss_cnt <= 4'h0;
      end else if (!active_d) begin
         ss_cnt <= ss_periods_f(cp_r[`LBT_SS_LSB +: 2]);
      end else if (pump_edge && pump_clk_o && ss_cnt != 4'h0) begin
         ss_cnt <= ss_cnt - 4'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         pump_soft_start_o <= 1'b0;
      end else begin
         pump_soft_start_o <= active && (!active_d || ss_cnt != 4'h0);
      end
   end

   // ------------------------------------------------------------
   // Read back
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         reg_rdata_o <= 8'h00;
      end else begin
         reg_rdata_o <= 8'h00;
         case (reg_addr_i)
            `LBT_ADDR_STATUS: reg_rdata_o <= {4'h0, pump_ratio_15x_o, ramp_dir, point_b, active};
            `LBT_ADDR_START: reg_rdata_o <= start_r;
            `LBT_ADDR_LEDS: reg_rdata_o <= leds_r;
            `LBT_ADDR_MODE: reg_rdata_o <= mode_r;
            `LBT_ADDR_CP: reg_rdata_o <= cp_r;
            default: begin
               for (int i = 0; i < `LBT_PAIRS; i++) begin
                  if (reg_addr_i == `LBT_ADDR_A_BASE + 8'(i)) begin
                     reg_rdata_o <= a_r[i];
                  end
                  if (reg_addr_i == `LBT_ADDR_B_BASE + 8'(i)) begin
                     reg_rdata_o <= b_r[i];
                  end
               end
            end
         endcase
      end
   end

endmodule

// file: rtl/lbt_pkg.sv
package lbt_pkg;
   typedef enum logic [1:0] {
      LBT_NORMAL,
      LBT_RAMP,
      LBT_BLINK,
      LBT_ALL_HIGH
   } lbt_mode_t;
endpackage
